/* hw/rhpc_top.sv */
// receive packet performance counters behind an axi4-lite slave
// assumes event inputs come from receive logic on CLK_I, one packet end per pulse
`include "rhpc_map.svh"
`default_nettype none

module rhpc_top
   import rhpc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int LEN_W = 16
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // packet events from the receive processor
   input wire logic PKT_END_I,
   input wire logic PKT_ABORT_I,
   input wire logic PKT_SIZE_VIOL_I,
   input wire logic [LEN_W-1:0] PKT_BYTES_I,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // axi4-lite read data
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // one byte lane of a wider counter
   function automatic rhpc_byte_t byte_of(input logic [31:0] val, input int unsigned n);
      byte_of = val[n*8 +: 8];
   endfunction

   // register index from a bus byte address
   function automatic rhpc_idx_t idx_of(input logic [ADDR_W-1:0] addr);
      idx_of = addr[`RHPC_IDX_HI:`RHPC_IDX_LO];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [23:0] apc_live, next_apc_live;
   logic [23:0] spc_live, next_spc_live;
   logic [31:0] gbc_live, next_gbc_live;
   logic [31:0] abc_live, next_abc_live;
   logic [23:0] apc_shot, next_apc_shot;
   logic [23:0] spc_shot, next_spc_shot;
   logic [31:0] gbc_shot, next_gbc_shot;
   logic [31:0] abc_shot, next_abc_shot;
   rhpc_req_e req, next_req;
   logic done, next_done;

   logic aw_held, next_aw_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic awready, next_awready;
   logic wready, next_wready;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic arready, next_arready;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;

   logic wr_fire;
   logic snap;
   logic [31:0] pkt_len;

   ////////////////////////////////////////////////////////////////////////////
   // write channel

   // address and data may arrive in either order; each is parked until both are in
   assign wr_fire = aw_held && w_held && !bvalid;
   // a write that raises the request bit while it is low is the snapshot moment
   assign snap = wr_fire && (idx_of(aw_addr) == `RHPC_IDX_UPD) && w_strb[0] &&
                 w_data[`RHPC_REQ_BIT] && (req == RHPC_REQ_LOW);

   // next write-channel state
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_req = req;
      if (S_AXI_AWVALID_I && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready) begin
         next_w_held = 1'b1;
         next_w_data = S_AXI_WDATA_I;
         next_w_strb = S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         unique case (idx_of(aw_addr))
            `RHPC_IDX_UPD: begin
               next_bresp = `RHPC_RESP_OKAY;
               if (w_strb[0]) begin
                  next_req = w_data[`RHPC_REQ_BIT] ? RHPC_REQ_HIGH : RHPC_REQ_LOW;
               end
            end
            // counters and status ignore writes but answer okay
            `RHPC_IDX_APC0, `RHPC_IDX_APC1, `RHPC_IDX_APC2,
            `RHPC_IDX_SPC0, `RHPC_IDX_SPC1, `RHPC_IDX_SPC2,
            `RHPC_IDX_GBC0, `RHPC_IDX_GBC1, `RHPC_IDX_GBC2, `RHPC_IDX_GBC3,
            `RHPC_IDX_ABC0, `RHPC_IDX_ABC1, `RHPC_IDX_ABC2, `RHPC_IDX_ABC3,
            `RHPC_IDX_UPDS: next_bresp = `RHPC_RESP_OKAY;
            default: next_bresp = `RHPC_RESP_SLVERR;
         endcase
      end else if (bvalid && S_AXI_BREADY_I) begin
         next_bvalid = 1'b0;
      end
      // each ready only while its own channel has nothing parked and no response waits, so outputs stay registered
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   // register write-channel state
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= `RHPC_RST_32;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RHPC_RESP_OKAY;
         awready <= 1'b0;
         wready <= 1'b0;
         req <= RHPC_REQ_LOW;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         awready <= next_awready;
         wready <= next_wready;
         req <= next_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counters and snapshot

   assign pkt_len = {{(32-LEN_W){1'b0}}, PKT_BYTES_I};

   // next counters; an event in the snapshot cycle starts the new interval
   always_comb begin
      logic [23:0] apc_inc;
      logic [23:0] spc_inc;
      logic [31:0] gbc_inc;
      logic [31:0] abc_inc;
      apc_inc = `RHPC_ZERO_24;
      spc_inc = `RHPC_ZERO_24;
      gbc_inc = `RHPC_ZERO_32;
      abc_inc = `RHPC_ZERO_32;
      if (PKT_END_I) begin
         if (PKT_ABORT_I) begin
            apc_inc = `RHPC_ONE_24;
         end
         if (PKT_SIZE_VIOL_I) begin
            spc_inc = `RHPC_ONE_24;
         end
         // any abort or size fault sends the length to the aborted bytes, once
         if (PKT_ABORT_I || PKT_SIZE_VIOL_I) begin
            abc_inc = pkt_len;
         end else begin
            // dropped-but-stored bytes are counted here by design
            gbc_inc = pkt_len;
         end
      end
      next_apc_shot = apc_shot;
      next_spc_shot = spc_shot;
      next_gbc_shot = gbc_shot;
      next_abc_shot = abc_shot;
      if (snap) begin
         next_apc_shot = apc_live;
         next_spc_shot = spc_live;
         next_gbc_shot = gbc_live;
         next_abc_shot = abc_live;
         next_apc_live = apc_inc;
         next_spc_live = spc_inc;
         next_gbc_live = gbc_inc;
         next_abc_live = abc_inc;
      end else begin
         // counters wrap silently; software samples often enough
         next_apc_live = apc_live + apc_inc;
         next_spc_live = spc_live + spc_inc;
         next_gbc_live = gbc_live + gbc_inc;
         next_abc_live = abc_live + abc_inc;
      end
      // done rises with the snapshot and falls once request is written low
      if (snap) begin
         next_done = 1'b1;
      end else if (next_req == RHPC_REQ_LOW) begin
         next_done = 1'b0;
      end else begin
         next_done = done;
      end
   end

   // register counters
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         apc_live <= `RHPC_RST_24;
         spc_live <= `RHPC_RST_24;
         gbc_live <= `RHPC_RST_32;
         abc_live <= `RHPC_RST_32;
         apc_shot <= `RHPC_RST_24;
         spc_shot <= `RHPC_RST_24;
         gbc_shot <= `RHPC_RST_32;
         abc_shot <= `RHPC_RST_32;
         done <= 1'b0;
      end else begin
         apc_live <= next_apc_live;
         spc_live <= next_spc_live;
         gbc_live <= next_gbc_live;
         abc_live <= next_abc_live;
         apc_shot <= next_apc_shot;
         spc_shot <= next_spc_shot;
         gbc_shot <= next_gbc_shot;
         abc_shot <= next_abc_shot;
         done <= next_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel

   // next read-channel state; one read in flight, answered the cycle after
   always_comb begin
      rhpc_byte_t b;
      logic hit;
      b = `RHPC_RST_8;
      hit = 1'b1;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      unique case (idx_of(S_AXI_ARADDR_I))
         `RHPC_IDX_APC0: b = byte_of({8'h00, apc_shot}, 0);
         `RHPC_IDX_APC1: b = byte_of({8'h00, apc_shot}, 1);
         `RHPC_IDX_APC2: b = byte_of({8'h00, apc_shot}, 2);
         `RHPC_IDX_SPC0: b = byte_of({8'h00, spc_shot}, 0);
         `RHPC_IDX_SPC1: b = byte_of({8'h00, spc_shot}, 1);
         `RHPC_IDX_SPC2: b = byte_of({8'h00, spc_shot}, 2);
         `RHPC_IDX_GBC0: b = byte_of(gbc_shot, 0);
         `RHPC_IDX_GBC1: b = byte_of(gbc_shot, 1);
         `RHPC_IDX_GBC2: b = byte_of(gbc_shot, 2);
         `RHPC_IDX_GBC3: b = byte_of(gbc_shot, 3);
         `RHPC_IDX_ABC0: b = byte_of(abc_shot, 0);
         `RHPC_IDX_ABC1: b = byte_of(abc_shot, 1);
         `RHPC_IDX_ABC2: b = byte_of(abc_shot, 2);
         `RHPC_IDX_ABC3: b = byte_of(abc_shot, 3);
         `RHPC_IDX_UPD: b = {7'h00, (req == RHPC_REQ_HIGH)};
         `RHPC_IDX_UPDS: b = {7'h00, done};
         default: hit = 1'b0;
      endcase
      if (S_AXI_ARVALID_I && arready) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, b};
         next_rresp = hit ? `RHPC_RESP_OKAY : `RHPC_RESP_SLVERR;
      end else if (rvalid && S_AXI_RREADY_I) begin
         next_rvalid = 1'b0;
      end
      next_arready = !next_rvalid;
   end

   // register read-channel state
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rvalid <= 1'b0;
         rdata <= `RHPC_RST_32;
         rresp <= `RHPC_RESP_OKAY;
         arready <= 1'b0;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         arready <= next_arready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops

   assign S_AXI_AWREADY_O = awready;
   assign S_AXI_WREADY_O = wready;
   assign S_AXI_BVALID_O = bvalid;
   assign S_AXI_BRESP_O = bresp;
   assign S_AXI_ARREADY_O = arready;
   assign S_AXI_RVALID_O = rvalid;
   assign S_AXI_RDATA_O = rdata;
   assign S_AXI_RRESP_O = rresp;

endmodule // rhpc_top
`default_nettype wire

/* shared/rhpc_map.svh */
// register indices, field positions and bus codes of the receive counter bank
// assumes the byte address of a register is four times its index
`ifndef RHPC_MAP_SVH
`define RHPC_MAP_SVH

// register indices (byte address = index * 4)
`define RHPC_IDX_APC0 9'h110
`define RHPC_IDX_APC1 9'h111
`define RHPC_IDX_APC2 9'h112
`define RHPC_IDX_SPC0 9'h114
`define RHPC_IDX_SPC1 9'h115
`define RHPC_IDX_SPC2 9'h116
`define RHPC_IDX_GBC0 9'h118
`define RHPC_IDX_GBC1 9'h119
`define RHPC_IDX_GBC2 9'h11a
`define RHPC_IDX_GBC3 9'h11b
`define RHPC_IDX_ABC0 9'h11c
`define RHPC_IDX_ABC1 9'h11d
`define RHPC_IDX_ABC2 9'h11e
`define RHPC_IDX_ABC3 9'h11f
`define RHPC_IDX_UPD 9'h120
`define RHPC_IDX_UPDS 9'h121

// index field of the bus address
`define RHPC_IDX_HI 10
`define RHPC_IDX_LO 2
// control bit positions
`define RHPC_REQ_BIT 0
`define RHPC_DONE_BIT 0

// reset values and counter increments
`define RHPC_RST_24 24'h000000
`define RHPC_RST_32 32'h00000000
`define RHPC_RST_8 8'h00
`define RHPC_ZERO_24 24'h000000
`define RHPC_ZERO_32 32'h00000000
`define RHPC_ONE_24 24'h000001

// axi responses
`define RHPC_RESP_OKAY 2'h0
`define RHPC_RESP_SLVERR 2'h2

`endif

/* shared/rhpc_pkg.sv */
// types shared by the receive counter bank
// assumes rhpc_map.svh is compiled alongside
`default_nettype none
package rhpc_pkg;
   typedef logic [7:0] rhpc_byte_t;
   typedef logic [8:0] rhpc_idx_t;
   typedef enum logic {RHPC_REQ_LOW, RHPC_REQ_HIGH} rhpc_req_e;
endpackage : rhpc_pkg
`default_nettype wire

/* sim/rhpc_top_monitor.sv */
// checker of the counter bank's axi4-lite slave handshakes and responses
// assumes it is bound into rhpc_top and sees only its ports
`include "rhpc_map.svh"
`default_nettype none
module rhpc_top_monitor
   import rhpc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int LEN_W = 16
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // write channels
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // read channels
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);
   timeunit 1ns;
   timeprecision 100ps;
   rhpc_idx_t ridx;
   logic hit;
   // holes at 0x113 and 0x117 are unmapped, like everything outside the bank
   assign ridx = S_AXI_ARADDR_I[`RHPC_IDX_HI:`RHPC_IDX_LO];
   assign hit = ridx >= 9'h110 && ridx <= 9'h121 && ridx != 9'h113 && ridx != 9'h117;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read not answered next cycle");
   a_read_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
      else $error("read answer changed before taken");
   a_byte_wide: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   a_read_unmapped: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && !hit |=>
      S_AXI_RRESP_O == `RHPC_RESP_SLVERR && S_AXI_RDATA_O == 32'h00000000)
      else $error("unmapped read not refused");
   a_read_okay: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && hit |=>
      S_AXI_RRESP_O == `RHPC_RESP_OKAY)
      else $error("mapped read refused");
   a_ar_gate: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read address accepted while answer pending");
   a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
      S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
      else $error("write not answered after two cycles");
   a_write_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write answer changed before taken");
   a_write_gate: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write accepted while answer pending");
endmodule // rhpc_top_monitor
bind rhpc_top rhpc_top_monitor #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) mon_u (.CLK_I(CLK_I),
   .RST_N_I(RST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
   .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));
`default_nettype wire

/* sim/rhpc_pkt_src.sv */
// model of the receive packet processor: one packet-end pulse per call
// assumes the bench calls send back to back and idle after a burst
`default_nettype none
module rhpc_pkt_src (
   // clock
   input wire logic clk_i,
   // packet events
   output logic end_o,
   output logic abort_o,
   output logic viol_o,
   output logic [15:0] bytes_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      end_o = 1'b0;
      abort_o = 1'b0;
      viol_o = 1'b0;
      bytes_o = 16'h5a5a;
   end
   // qualifiers only mean something with the pulse; between pulses they are scrambled
   task send(input logic a, input logic v, input logic [15:0] n);
      @(posedge clk_i);
      end_o <= 1'b1;
      abort_o <= a;
      viol_o <= v;
      bytes_o <= n;
   endtask
   task idle;
      @(posedge clk_i);
      end_o <= 1'b0;
      abort_o <= ~abort_o;
      viol_o <= ~viol_o;
      bytes_o <= ~bytes_o;
   endtask
endmodule // rhpc_pkt_src
`default_nettype wire

/* sim/rx_hdlc_perf_counters_bench.sv */
// self-checking bench of the receive counter bank over axi4-lite
// assumes rhpc_top, its checker and the packet source model are compiled first
`include "rhpc_map.svh"
`default_nettype none
module rx_hdlc_perf_counters_bench
   import rhpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK_I = 1'b0, RST_N_I = 1'b0;
   logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
   logic [31:0] w_d = 32'h0, r_d;
   logic [3:0] w_s = 4'h0;
   logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, p_end, p_ab, p_sv, req_q = 1'b0;
   logic [1:0] b_rs, r_rs;
   logic [15:0] p_n;
   logic [31:0] live [4] = '{default: 32'h0}, snap [4] = '{default: 32'h0};
   int num_errors = 0, checked = 0;
   always #2.5 CLK_I = ~CLK_I;
   rhpc_top #(.ADDR_W(12), .LEN_W(16)) dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
      .PKT_END_I(p_end), .PKT_ABORT_I(p_ab), .PKT_SIZE_VIOL_I(p_sv), .PKT_BYTES_I(p_n),
      .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy),
      .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(w_s), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
      .S_AXI_BRESP_O(b_rs), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_r),
      .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
      .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_rs), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r));
   rhpc_pkt_src src_u (.clk_i(CLK_I), .end_o(p_end), .abort_o(p_ab), .viol_o(p_sv),
      .bytes_o(p_n));
   ////////////////////////////////////////////////////////////////////////////////
   // reporting
   task conclude;
      $display("checked %0d, wrong %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk_data(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask
   task chk_resp(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: response %h, expected %h", $time, got, exp);
      end
   endtask
   task hang;
      num_errors++;
      $display("wrong value at %0t: bus never answered", $time);
      conclude();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // bus cycles: requests held until taken, readies held until the answer
   task wr(input rhpc_idx_t k, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      int n;
      @(posedge CLK_I);
      {aw_a, w_d, w_s, aw_v, w_v, b_r} <= {1'b0, k, 2'b00, d, s, 3'b111};
      for (n = 0; n <= 50; n++) begin
         @(posedge CLK_I);
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
         if (b_v === 1'b1) break;
      end
      if (n > 50) hang();
      chk_resp(b_rs, e);
      b_r <= 1'b0;
   endtask
   task rd(input rhpc_idx_t k, input logic [31:0] ed, input logic [1:0] e);
      int n;
      @(posedge CLK_I);
      {ar_a, ar_v, r_r} <= {1'b0, k, 2'b00, 2'b11};
      for (n = 0; n <= 50; n++) begin
         @(posedge CLK_I);
         if (ar_rdy) ar_v <= 1'b0;
         if (r_v === 1'b1) break;
      end
      if (n > 50) hang();
      chk_data(r_d, ed);
      chk_resp(r_rs, e);
      r_r <= 1'b0;
   endtask
   // counter bytes are read one by one from the frozen snapshot
   task rd_all;
      for (int i = 0; i < 4; i++) begin
         if (i < 3) rd(`RHPC_IDX_APC0 + i[8:0], {24'h0, snap[0][8*i+:8]}, 2'h0);
         if (i < 3) rd(`RHPC_IDX_SPC0 + i[8:0], {24'h0, snap[1][8*i+:8]}, 2'h0);
         rd(`RHPC_IDX_GBC0 + i[8:0], {24'h0, snap[2][8*i+:8]}, 2'h0);
         rd(`RHPC_IDX_ABC0 + i[8:0], {24'h0, snap[3][8*i+:8]}, 2'h0);
      end
   endtask
   task pkts(input int c, input logic a, input logic v, input logic [15:0] n);
      repeat (c) begin
         src_u.send(a, v, n);
         live[0] += {31'h0, a};
         live[1] += {31'h0, v};
         if (a || v) live[3] += {16'h0, n};
         else live[2] += {16'h0, n};
      end
      src_u.idle();
   endtask
   task req(input logic v, input logic [3:0] s);
      wr(`RHPC_IDX_UPD, {31'h0, v}, s, 2'h0);
      if (s[0] && v && !req_q) begin
         snap = live;
         live = '{default: 32'h0};
      end
      if (s[0]) req_q = v;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_reset;
      rd_all();
      rd(`RHPC_IDX_UPDS, 32'h0, 2'h0);
      wr(`RHPC_IDX_APC0, 32'hff, 4'hf, 2'h0);
      wr(`RHPC_IDX_GBC3, 32'h5a, 4'hf, 2'h0);
      rd_all();
      wr(9'h113, 32'h1, 4'hf, `RHPC_RESP_SLVERR);
      rd(9'h117, 32'h0, `RHPC_RESP_SLVERR);
      rd(9'h1ff, 32'h0, `RHPC_RESP_SLVERR);
      $display("test reset done");
   endtask
   task t_tally;
      pkts(257, 1'b1, 1'b1, 16'hffff);
      pkts(258, 1'b0, 1'b0, 16'hffff);
      pkts(3, 1'b1, 1'b0, 16'h0010);
      pkts(2, 1'b0, 1'b1, 16'h0021);
      req(1'b1, 4'h1);
      rd(`RHPC_IDX_UPDS, 32'h1, 2'h0);
      rd_all();
      $display("test tally done");
   endtask
   task t_snapshot;
      req(1'b0, 4'h1);
      rd(`RHPC_IDX_UPDS, 32'h0, 2'h0);
      pkts(1, 1'b0, 1'b0, 16'h0007);
      rd_all();
      req(1'b1, 4'h1);
      rd_all();
      pkts(1, 1'b1, 1'b0, 16'h0005);
      req(1'b1, 4'h1);
      req(1'b0, 4'h0);
      rd(`RHPC_IDX_UPD, 32'h1, 2'h0);
      rd(`RHPC_IDX_UPDS, 32'h1, 2'h0);
      rd_all();
      req(1'b0, 4'h1);
      rd(`RHPC_IDX_UPD, 32'h0, 2'h0);
      req(1'b1, 4'h1);
      rd_all();
      $display("test snapshot done");
   endtask
   initial begin
      repeat (8) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      t_reset();
      t_tally();
      t_snapshot();
      conclude();
   end
endmodule // rx_hdlc_perf_counters_bench
`default_nettype wire
